/* File: hw/ssc_channel.sv */
// Synchronous character-oriented serial channel with an APB register port.
// Assumes modem pins are asynchronous; bit clocks are far slower than i_core_clk.
`include "ssc_consts.svh"

module ssc_channel (
	input  wire logic                     i_core_clk,
	input  wire logic                     i_resetn,
	input  wire logic                     i_psel,
	input  wire logic                     i_penable,
	input  wire logic                     i_pwrite,
	input  wire logic [11:0]              i_paddr,
	input  wire logic [31:0]              i_pwdata,
	output logic      [31:0]              o_prdata,
	output logic                          o_pready,
	output logic                          o_pslverr,
	input  wire ssc_pkg::ssc_modem_in_type  i_modem,
	output ssc_pkg::ssc_modem_out_type      o_modem,
	output logic                          o_irq
);

	// ***********************************************************
	// Functions
	// ***********************************************************
	function automatic logic [3:0] char_len(input ssc_pkg::ssc_len_type sel);
		case (sel)
			ssc_pkg::SSC_LEN_5: char_len = `SSC_LEN5;
			ssc_pkg::SSC_LEN_6: char_len = `SSC_LEN6;
			ssc_pkg::SSC_LEN_7: char_len = `SSC_LEN7;
			default:            char_len = `SSC_LEN8;
		endcase
	endfunction

	function automatic logic [8:0] len_mask(input ssc_pkg::ssc_len_type sel);
		len_mask = 9'(9'h1FF >> (4'd9 - char_len(sel)));
	endfunction

	function automatic logic [8:0] sync_pat(input ssc_pkg::ssc_len_type sel);
		case (sel)
			ssc_pkg::SSC_LEN_5: sync_pat = `SSC_SYNC5 & len_mask(sel);
			ssc_pkg::SSC_LEN_6: sync_pat = `SSC_SYNC6 & len_mask(sel);
			ssc_pkg::SSC_LEN_7: sync_pat = `SSC_SYNC7 & len_mask(sel);
			default:            sync_pat = `SSC_SYNC8 & len_mask(sel);
		endcase
	endfunction

	function automatic logic is_sync(input logic [8:0] v, input ssc_pkg::ssc_len_type sel);
		is_sync = (v & len_mask(sel)) == sync_pat(sel);
	endfunction

	// Character in the low bits with a one just above it, so emptiness shows as zeros.
	function automatic logic [8:0] with_marker(input logic [8:0] v, input ssc_pkg::ssc_len_type sel);
		with_marker = (v & len_mask(sel)) | 9'(9'h001 << char_len(sel));
	endfunction

	function automatic logic [`SSC_RIP_CNT_W-1:0] cycles_ceil(input int ns);
		cycles_ceil = `SSC_RIP_CNT_W'((ns + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS);
	endfunction

	// ***********************************************************
	// Pin synchronisation and edge detection
	// ***********************************************************
	ssc_pkg::ssc_modem_in_type pins;
	logic                      rx_clk_prev;
	logic                      tx_clk_prev;
	logic                      power_init;
	logic                      rx_clk_pulse;
	logic                      tx_clk_pulse;

	ssc_pin_sync #(.WIDTH(6)) u_sync (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_async    (i_modem),
		.o_sync     (pins)
	);

	assign power_init = !i_resetn;

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			rx_clk_prev <= 1'b0;
			tx_clk_prev <= 1'b0;
		end else begin
			rx_clk_prev <= pins.rx_clk;
			tx_clk_prev <= pins.tx_clk;
		end
	end

	// Shaping and inverting twice leaves the sampling moment at the pin's rising edge.
	assign rx_clk_pulse = pins.rx_clk && !rx_clk_prev;
	assign tx_clk_pulse = pins.tx_clk && !tx_clk_prev && pins.cts;

	// ***********************************************************
	// Control register and APB decode
	// ***********************************************************
	logic [9:0]           ctrl;
	ssc_pkg::ssc_len_type len_sel;
	logic [1:0]           rip_sel;
	logic                 apb_setup;
	logic                 apb_done;
	logic                 wr_ctrl;
	logic                 wr_cmd;
	logic                 wr_tx;
	logic                 rd_rx;
	logic                 addr_ok;

	assign len_sel   = ssc_pkg::ssc_len_type'(ctrl[`SSC_CTRL_LEN_HI:`SSC_CTRL_LEN_LO]);
	assign rip_sel   = ctrl[`SSC_CTRL_RIP_HI:`SSC_CTRL_RIP_LO];
	assign apb_setup = i_psel && !i_penable;
	assign apb_done  = i_psel && i_penable && o_pready;
	assign wr_ctrl   = apb_done && i_pwrite && i_paddr == `SSC_OFS_CTRL;
	assign wr_cmd    = apb_done && i_pwrite && i_paddr == `SSC_OFS_CMD;
	assign wr_tx     = apb_done && i_pwrite && i_paddr == `SSC_OFS_TXDATA;
	assign rd_rx     = apb_done && !i_pwrite && i_paddr == `SSC_OFS_RXDATA;
	assign addr_ok   = i_paddr == `SSC_OFS_CTRL || i_paddr == `SSC_OFS_STATUS ||
	                   i_paddr == `SSC_OFS_CMD || i_paddr == `SSC_OFS_TXDATA ||
	                   i_paddr == `SSC_OFS_RXDATA || i_paddr == `SSC_OFS_SKIP;

	// Ring enable, terminal ready and idle mode change only by program writes.
	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			ctrl <= `SSC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= i_pwdata[9:0];
		end
	end

	// ***********************************************************
	// Receive path
	// ***********************************************************
	logic [8:0]                rx_shift_reg;
	logic [8:0]                rx_char_buffer;
	logic [3:0]                rx_bits;
	logic                      rx_active;
	logic                      rx_char_flag;
	logic [`SSC_RIP_CNT_W-1:0] rip_cnt;
	logic [`SSC_RIP_CNT_W-1:0] rip_limit;
	logic                      rip_expired;
	logic [8:0]                next_rx_shift;
	logic                      rx_sync_match;
	logic                      rx_char_done;

	always_comb begin
		case (rip_sel)
			2'b00:   rip_limit = cycles_ceil(`SSC_RIP0_NS);
			2'b01:   rip_limit = cycles_ceil(`SSC_RIP1_NS);
			2'b10:   rip_limit = cycles_ceil(`SSC_RIP2_NS);
			default: rip_limit = cycles_ceil(`SSC_RIP3_NS);
		endcase
	end

	assign next_rx_shift = {rx_shift_reg[7:0], pins.rx_data};
	assign rx_sync_match = is_sync(next_rx_shift, len_sel);
	assign rx_char_done  = rx_clk_pulse && rx_active && (rx_bits + 4'd1 == char_len(len_sel));
	assign rip_expired   = rip_cnt >= rip_limit;

	// Retriggered by every rising receive clock edge; runs out only on a pause.
	always_ff @(posedge i_core_clk) begin
		if (power_init || rx_clk_pulse) begin
			rip_cnt <= '0;
		end else if (!rip_expired) begin
			rip_cnt <= rip_cnt + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			rx_shift_reg <= '0;
		end else if (rx_clk_pulse) begin
			rx_shift_reg <= next_rx_shift;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			rx_active <= 1'b0;
			rx_bits   <= '0;
		end else if (rx_active && rip_expired) begin
			rx_active <= 1'b0;
			rx_bits   <= '0;
		end else if (rx_clk_pulse && !rx_active && rx_sync_match) begin
			rx_active <= 1'b1;
			rx_bits   <= '0;
		end else if (rx_char_done) begin
			rx_bits <= '0;
		end else if (rx_clk_pulse && rx_active) begin
			rx_bits <= rx_bits + 4'd1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			rx_char_buffer <= '0;
		end else if (rx_char_done) begin
			rx_char_buffer <= next_rx_shift & len_mask(len_sel);
		end
	end

	// A new character in the cycle of the buffer read keeps the flag set.
	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			rx_char_flag <= 1'b0;
		end else if (rx_char_done) begin
			rx_char_flag <= 1'b1;
		end else if (rd_rx) begin
			rx_char_flag <= 1'b0;
		end
	end

	// ***********************************************************
	// Transmit path
	// ***********************************************************
	logic [8:0]                 tx_char_buffer;
	logic                       tcb_full;
	logic [8:0]                 tx_shift_reg;
	logic                       tx_active;
	ssc_pkg::ssc_tx_state_type  tx_state;
	logic                       tx_loaded_flag;
	logic                       send_req;
	logic                       tx_bit;
	logic                       tcb_sync;
	logic                       last_bit;
	logic                       start_tx;
	logic                       reload;
	logic                       tcb_to_tb;
	logic [8:0]                 next_load;

	assign tcb_sync  = is_sync({1'b0, tx_char_buffer[7:0]}, len_sel);
	assign last_bit  = tx_shift_reg[8:2] == 7'h00 && !tx_shift_reg[1];
	assign start_tx  = !tx_active && tcb_full && tcb_sync;
	assign reload    = tx_active && tx_clk_pulse && last_bit;
	assign tcb_to_tb = start_tx || (reload && tcb_full);
	assign next_load = tcb_full ? with_marker(tx_char_buffer, len_sel)
	                            : with_marker(sync_pat(len_sel), len_sel);
	assign tx_active = tx_state == ssc_pkg::SSC_TX_SEND;

	// A write in the cycle the buffer empties is kept; the buffer stays full.
	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			tx_char_buffer <= '0;
			tcb_full       <= 1'b0;
		end else if (wr_tx) begin
			tx_char_buffer <= i_pwdata[8:0];
			tcb_full       <= 1'b1;
		end else if (tcb_to_tb) begin
			tcb_full <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			tx_state <= ssc_pkg::SSC_TX_IDLE;
		end else begin
			case (tx_state)
				ssc_pkg::SSC_TX_IDLE: begin
					if (start_tx) begin
						tx_state <= ssc_pkg::SSC_TX_SEND;
					end
				end
				ssc_pkg::SSC_TX_SEND: begin
					if (reload && !tcb_full && !ctrl[`SSC_CTRL_IDLE]) begin
						tx_state <= ssc_pkg::SSC_TX_IDLE;
					end
				end
				default: tx_state <= ssc_pkg::SSC_TX_IDLE;
			endcase
		end
	end

	// In idle mode a late character is replaced by a sync fill character.
	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			tx_shift_reg <= '0;
			tx_bit       <= 1'b0;
		end else if (start_tx) begin
			tx_shift_reg <= with_marker(tx_char_buffer, len_sel);
		end else if (reload && (tcb_full || ctrl[`SSC_CTRL_IDLE])) begin
			tx_shift_reg <= {1'b0, next_load[8:1]};
			tx_bit       <= next_load[0];
		end else if (tx_active && tx_clk_pulse && !last_bit) begin
			tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
			tx_bit       <= tx_shift_reg[0];
		end else if (!tx_active) begin
			tx_bit <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			tx_loaded_flag <= 1'b0;
		end else if (tcb_to_tb) begin
			tx_loaded_flag <= 1'b1;
		end else if (wr_cmd && i_pwdata[`SSC_CMD_CLR_TX]) begin
			tx_loaded_flag <= 1'b0;
		end
	end

	// Turned on at sync delivery, dropped one bit clock after transmission ends.
	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			send_req <= 1'b0;
		end else if (start_tx) begin
			send_req <= 1'b1;
		end else if (pins.tx_clk && !tx_clk_prev) begin
			send_req <= tx_active;
		end
	end

	// ***********************************************************
	// Modem control
	// ***********************************************************
	logic ring_flag;

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			ring_flag <= 1'b0;
		end else if (pins.ring) begin
			ring_flag <= 1'b1;
		end else if (wr_cmd && i_pwdata[`SSC_CMD_CLR_RING]) begin
			ring_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			o_modem <= '0;
			o_irq   <= 1'b0;
		end else begin
			o_modem.tx_data <= tx_bit;
			o_modem.rts     <= send_req;
			o_modem.dtr     <= ctrl[`SSC_CTRL_TERM_RDY];
			o_irq           <= (rx_char_flag && ctrl[`SSC_CTRL_RX_IE]) ||
			                   (tx_loaded_flag && ctrl[`SSC_CTRL_TX_IE]) ||
			                   (ring_flag && ctrl[`SSC_CTRL_RING_EN]);
		end
	end

	// ***********************************************************
	// APB read data and handshake
	// ***********************************************************
	logic [31:0] rd_value;

	always_comb begin
		rd_value = 32'h0000_0000;
		case (i_paddr)
			`SSC_OFS_CTRL:   rd_value = {22'h00_0000, ctrl};
			`SSC_OFS_STATUS: rd_value = {23'h00_0000, o_modem.rts, pins.cts, pins.dsr,
			                             tcb_full, tx_active, rx_active, ring_flag,
			                             tx_loaded_flag, rx_char_flag};
			`SSC_OFS_TXDATA: rd_value = {23'h00_0000, tx_char_buffer};
			`SSC_OFS_RXDATA: rd_value = {23'h00_0000, rx_char_buffer};
			`SSC_OFS_SKIP:   rd_value = {31'h0000_0000, ring_flag};
			default:         rd_value = 32'h0000_0000;
		endcase
	end

	// Answer is prepared in the setup cycle so every bus output is a flip-flop.
	always_ff @(posedge i_core_clk) begin
		if (power_init) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else if (apb_setup) begin
			o_pready  <= 1'b1;
			o_pslverr <= !addr_ok;
			o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_value;
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

endmodule

/* File: hw/ssc_consts.svh */
// Constants of the synchronous serial communication channel.
// Assumes a single 125 MHz core clock and an APB register port.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ***********************************************************
// Clock and timing
// ***********************************************************
`define SSC_CLK_PERIOD_NS   8
`define SSC_RIP0_NS         2000
`define SSC_RIP1_NS         4000
`define SSC_RIP2_NS         8000
`define SSC_RIP3_NS         16000
`define SSC_RIP_CNT_W       12

// ***********************************************************
// Register offsets (byte addresses)
// ***********************************************************
`define SSC_OFS_CTRL        12'h000
`define SSC_OFS_STATUS      12'h004
`define SSC_OFS_CMD         12'h008
`define SSC_OFS_TXDATA      12'h00C
`define SSC_OFS_RXDATA      12'h010
`define SSC_OFS_SKIP        12'h014

// ***********************************************************
// Control fields
// ***********************************************************
`define SSC_CTRL_RING_EN    0
`define SSC_CTRL_TERM_RDY   1
`define SSC_CTRL_IDLE       2
`define SSC_CTRL_LEN_LO     3
`define SSC_CTRL_LEN_HI     4
`define SSC_CTRL_RIP_LO     5
`define SSC_CTRL_RIP_HI     6
`define SSC_CTRL_RX_IE      8
`define SSC_CTRL_TX_IE      9
`define SSC_CTRL_RESET      10'h000

// ***********************************************************
// Command bits
// ***********************************************************
`define SSC_CMD_CLR_RING    0
`define SSC_CMD_CLR_TX      1

// ***********************************************************
// Character lengths and sync patterns
// ***********************************************************
`define SSC_LEN5            4'h5
`define SSC_LEN6            4'h6
`define SSC_LEN7            4'h7
`define SSC_LEN8            4'h8
`define SSC_SYNC5           9'h016
`define SSC_SYNC6           9'h016
`define SSC_SYNC7           9'h016
`define SSC_SYNC8           9'h016

`endif

/* File: hw/ssc_pkg.sv */
// Types of the synchronous serial communication channel.
// Assumes ssc_consts.svh is available for the numeric constants.
package ssc_pkg;

	typedef enum logic [1:0] {
		SSC_LEN_5 = 2'b00,
		SSC_LEN_6 = 2'b01,
		SSC_LEN_7 = 2'b10,
		SSC_LEN_8 = 2'b11
	} ssc_len_type;

	typedef enum logic [1:0] {
		SSC_TX_IDLE  = 2'b00,
		SSC_TX_SEND  = 2'b01
	} ssc_tx_state_type;

	typedef struct packed {
		logic rx_clk;
		logic rx_data;
		logic tx_clk;
		logic cts;
		logic ring;
		logic dsr;
	} ssc_modem_in_type;

	typedef struct packed {
		logic tx_data;
		logic rts;
		logic dtr;
	} ssc_modem_out_type;

endpackage

/* File: hw/ssc_pin_sync.sv */
// Two flip-flop synchroniser for a group of modem pins.
// Assumes the pins are asynchronous to i_core_clk.
module ssc_pin_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule

/* File: testbench/ssc_modem_model.sv */
// Behavioural data set facing the channel's modem pins.
// Assumes the bench drives its controls and calls send_bits by hierarchical name.
module ssc_modem_model (
	input  wire logic                 i_rts,
	input  wire logic                 i_tx_data,
	input  wire logic                 i_dtr,
	output ssc_pkg::ssc_modem_in_type o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************
	// Pins and capture
	// ********************************
	logic        rx_clk  = 1'b0;
	logic        rx_data = 1'b1;
	logic        tx_clk  = 1'b0;
	logic        tx_run  = 1'b0;
	logic        cts_on  = 1'b0;
	logic        ring_on = 1'b0;
	logic        armed   = 1'b0;
	logic [63:0] cap     = '0;
	int          cap_n   = 0;
	// Data set ready is looped back from terminal ready, as a test plug would.
	assign o_pins = {rx_clk, rx_data, tx_clk, cts_on, ring_on, i_dtr};
	// The receive clock runs only inside a frame; after it the data line shows the inverse.
	task automatic send_bits(input logic [23:0] v);
		for (int i = 23; i >= 0; i--) begin
			rx_data = v[i];
			#80 rx_clk = 1'b1;
			#80 rx_clk = 1'b0;
		end
		rx_data = ~v[0];
	endtask
	initial begin
		#3;
		forever begin
			#80 tx_clk = tx_run ? ~tx_clk : 1'b0;
		end
	end
	// A bit is only taken after a rising edge seen with the request and clear-to-send up.
	always @(posedge tx_clk) armed = cts_on && i_rts;
	always @(negedge tx_clk) begin
		if (armed && cap_n < 64) begin
			cap[cap_n] = i_tx_data;
			cap_n++;
		end
	end
endmodule

/* File: testbench/ssc_channel_props.sv */
// Concurrent checks on the ports of the serial channel.
// Assumes one core clock domain with a synchronous active-low reset.
`include "ssc_consts.svh"

module ssc_channel_props (
	input wire logic                       i_core_clk,
	input wire logic                       i_resetn,
	input wire logic                       i_psel,
	input wire logic                       i_penable,
	input wire logic                       i_pwrite,
	input wire logic [11:0]                i_paddr,
	input wire logic [31:0]                i_pwdata,
	input wire logic [31:0]                o_prdata,
	input wire logic                       o_pready,
	input wire logic                       o_pslverr,
	input wire ssc_pkg::ssc_modem_in_type  i_modem,
	input wire ssc_pkg::ssc_modem_out_type o_modem,
	input wire logic                       o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************
	// Helper state
	// ********************************
	logic [9:0] ctrl;
	logic [3:0] ctrl_age;
	logic [3:0] clk_age;
	logic       clk_d;
	logic       ctrl_wr;
	assign ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == `SSC_OFS_CTRL;
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			ctrl     <= 10'h000;
			ctrl_age <= 4'hF;
		end else if (ctrl_wr) begin
			ctrl     <= i_pwdata[9:0];
			ctrl_age <= 4'h0;
		end else if (ctrl_age != 4'hF) begin
			ctrl_age <= ctrl_age + 4'h1;
		end
	end
	// Ages are counted from the raw pin edge, so the sync flops' delay sits inside the bound.
	always_ff @(posedge i_core_clk) begin
		clk_d <= i_modem.tx_clk;
		if (!i_resetn) clk_age <= 4'hF;
		else if (i_modem.tx_clk && !clk_d) clk_age <= 4'h0;
		else if (clk_age != 4'hF) clk_age <= clk_age + 4'h1;
	end
	// ********************************
	// Assertions
	// ********************************
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	chk_pready_zero_wait: assert property (i_psel && !i_penable |=> o_pready)
		else $error("ready missing in first access cycle");
	chk_pready_single: assert property (o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	chk_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	chk_reset_outputs: assert property ($rose(i_resetn) |-> o_modem == '0 && !o_irq)
		else $error("outputs not cleared by reset");
	chk_dtr_follows: assert property (ctrl_age >= 4'h3 |-> o_modem.dtr == ctrl[1])
		else $error("terminal ready differs from control");
	chk_irq_masked: assert property (ctrl_age >= 4'h3 && ctrl[0] == 1'b0 && ctrl[8] == 1'b0
		&& ctrl[9] == 1'b0 |-> !o_irq)
		else $error("interrupt with all enables off");
	chk_tx_on_clock: assert property ($changed(o_modem.tx_data) |-> clk_age <= 4'h8)
		else $error("transmit data moved without clock edge");
	chk_rts_drop: assert property ($fell(o_modem.rts) |-> clk_age <= 4'h8)
		else $error("request to send fell off clock");
	chk_cts_hold: assert property ((!i_modem.cts) [*6] |=> $stable(o_modem.tx_data))
		else $error("transmit shifted without clear to send");
endmodule

bind ssc_channel ssc_channel_props u_props (.i_core_clk, .i_resetn, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_modem, .o_modem,
	.o_irq);

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial channel: APB master, data set model, checks.
// Assumes the property checker is bound in from its own file.
`include "ssc_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************
	// Harness
	// ********************************
	logic                       clk     = 1'b0;
	logic                       resetn  = 1'b0;
	logic                       psel    = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite  = 1'b0;
	logic [11:0]                paddr   = 12'h000;
	logic [31:0]                pwdata  = 32'h0000_0000;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic                       irq;
	ssc_pkg::ssc_modem_in_type  modem_in;
	ssc_pkg::ssc_modem_out_type modem_out;
	logic [31:0]                rd;
	logic                       err;
	logic [31:0]                v;
	logic [23:0]                frame;
	logic [8:0]                 sy;
	logic [8:0]                 ch;
	logic [15:0]                seed    = 16'h188F;
	int                         nb;
	int                         miscompares = 0;
	int                         check_count = 0;
	int                         cycles      = 0;
	always #4 clk = ~clk;
	ssc_channel uut (.i_core_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_modem(modem_in), .o_modem(modem_out),
		.o_irq(irq));
	ssc_modem_model modem (.i_rts(modem_out.rts), .i_tx_data(modem_out.tx_data),
		.i_dtr(modem_out.dtr), .o_pins(modem_in));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [8:0] sync_for(input int n);
		return `SSC_SYNC8 & ((9'h001 << n) - 9'h001);
	endfunction
	task automatic summarize();
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask
	// Ready is sampled at the rising edge that completes the access; release follows it.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(name, e, rd & m);
	endtask
	task automatic tx_msg(input logic idle);
		logic [7:0] d;
		seed = lfsr(seed);
		d = seed[7:0];
		apb(1'b1, `SSC_OFS_CTRL, 32'h0000_021A | {29'h0, idle, 2'b00});
		modem.cap_n <= 0;
		apb(1'b1, `SSC_OFS_TXDATA, 32'h0000_0055);
		rdc("start on data", `SSC_OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
		apb(1'b1, `SSC_OFS_TXDATA, {23'h0, `SSC_SYNC8});
		modem.tx_run <= 1'b1;
		repeat (80) @(posedge clk);
		@(negedge clk);
		chk("data without cts", 32'h0, {31'h0, modem_out.tx_data});
		modem.tx_run <= 1'b0;
		repeat (30) @(posedge clk);
		modem.cts_on <= 1'b1;
		repeat (10) @(posedge clk);
		modem.tx_run <= 1'b1;
		rdc("tx started", `SSC_OFS_STATUS, 32'h0000_0112, 32'h0000_0112);
		apb(1'b1, `SSC_OFS_CMD, 32'h0000_0002);
		rdc("tx flag clear", `SSC_OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
		apb(1'b1, `SSC_OFS_TXDATA, {24'h0, d});
		for (int n = 0; n < 900 && modem.cap_n < (idle ? 24 : 16); n++) @(posedge clk);
		chk("tx bits", {16'h0, d, 8'h16}, {16'h0, modem.cap[15:0]});
		rdc("tx flag reload", `SSC_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
		if (idle) begin
			chk("idle fill", 32'h0000_0016, {24'h0, modem.cap[23:16]});
			apb(1'b1, `SSC_OFS_CTRL, 32'h0000_021A);
		end
		for (int n = 0; n < 900 && modem_out.rts !== 1'b0; n++) @(posedge clk);
		rdc("tx ended", `SSC_OFS_STATUS, 32'h0000_0110, 32'h0000_0000);
		modem.tx_run <= 1'b0;
		modem.cts_on <= 1'b0;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			summarize();
		end
	end
	// ********************************
	// Main sequence
	// ********************************
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rdc("ctrl reset", `SSC_OFS_CTRL, 32'h0000_037F, 32'h0000_0000);
		rdc("status reset", `SSC_OFS_STATUS, 32'h0000_01FF, 32'h0000_0000);
		rdc("unmapped", 12'h018, 32'hFFFF_FFFF, 32'h0000_0000);
		chk("unmapped error", 32'h1, {31'h0, err});
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = {16'h0, seed} & 32'h0000_037F;
			apb(1'b1, `SSC_OFS_CTRL, v);
			rdc("ctrl", `SSC_OFS_CTRL, 32'h0000_037F, v);
			rdc("dsr loop", `SSC_OFS_STATUS, 32'h0000_0040, {25'h0, v[1], 6'h0});
		end
		for (int l = 0; l < 4; l++) begin
			nb = 5 + l;
			sy = sync_for(nb);
			seed = lfsr(seed);
			ch = seed[8:0] & ((9'h001 << nb) - 9'h001);
			if (ch == sy) ch = ch ^ 9'h001;
			apb(1'b1, `SSC_OFS_CTRL, 32'h0000_0100 | 32'(l << 5) | 32'(l << 3));
			frame = (24'hFF_FFFF << (2 * nb)) | (24'(sy) << nb) | 24'(ch);
			modem.send_bits(frame);
			rd = 32'h0000_0000;
			for (int n = 0; n < 40 && rd[0] !== 1'b1; n++) apb(1'b0, `SSC_OFS_STATUS, 32'h0);
			chk("rx flag active", 32'h0000_0009, rd & 32'h0000_0009);
			@(negedge clk);
			chk("rx irq", 32'h1, {31'h0, irq});
			rdc("rx char", `SSC_OFS_RXDATA, 32'h0000_01FF, {23'h0, ch});
			repeat (2) @(negedge clk);
			chk("rx irq drop", 32'h0, {31'h0, irq});
			rdc("rx flag read", `SSC_OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
			repeat ((125 << l) - 20) @(posedge clk);
			rdc("rx held", `SSC_OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
			repeat ((125 << l) + 100) @(posedge clk);
			rdc("rx timeout", `SSC_OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
		end
		tx_msg(1'b0);
		tx_msg(1'b1);
		apb(1'b1, `SSC_OFS_CTRL, 32'h0000_0001);
		modem.ring_on <= 1'b1;
		repeat (8) @(posedge clk);
		rdc("ring skip", `SSC_OFS_SKIP, 32'h0000_0001, 32'h0000_0001);
		modem.ring_on <= 1'b0;
		@(negedge clk);
		chk("ring irq", 32'h1, {31'h0, irq});
		apb(1'b1, `SSC_OFS_CMD, 32'h0000_0001);
		rdc("ring clear", `SSC_OFS_SKIP, 32'h0000_0001, 32'h0000_0000);
		@(negedge clk);
		chk("ring irq drop", 32'h0, {31'h0, irq});
		summarize();
	end
endmodule
